// ===== design/dual_preset_timer.sv
/*
 * Dual-preset process timer core with mode decode and Wishbone registers.
 * Assumes a classic Wishbone master, a count tick from the timebase,
 * and run/stop and user reset inputs already synchronous to clk_in.
 */
`timescale 1ns/100ps

// Functional notes
// - Modes 1 to 18 keep counting when output 2 fires; only run/stop halts them.
// - Modes 19 to 42 halt counting when output 2 fires until a reset or run/stop cycle.
// - Modes 1 to 5 reset manually to zero with the five output combinations in order.
// - Modes 6 to 10 reset manually to preset 2 with the same five combinations.
// - Modes 11 to 14 auto-reset when output 2 fires, zero or preset 2, output 2 timed.
// - Modes 15 to 18 auto-reset when the timed output 2 interval ends.
// - Modes 19 to 28 copy modes 1 to 10 but halt when output 2 fires.
// - Modes 29 to 38 halt and auto-reset when output 2 fires, five combinations each.
// - Modes 39 to 42 halt when output 2 fires and auto-reset when the timed output 2 interval ends.
// - With reset to zero a reset clears the value and output 2 fires counting up to preset 2.
// - With reset to preset a reset loads preset 2 and output 2 fires counting down to zero.
// - An off-at-2 output 1 turns on at preset 1 and off when output 2 turns on.
// - In halt modes a manual reset restarts and clears outputs; run/stop restarts only.
module dual_preset_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [preset_timer_pkg::ADDR_W-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [preset_timer_pkg::DATA_W-1:0] wb_dat_in,
    output logic [preset_timer_pkg::DATA_W-1:0] wb_dat_out,
    output logic wb_ack_out,
    output logic wb_err_out,
    // Unit inputs
    input wire logic count_tick_in,
    input wire logic run_in,
    input wire logic user_reset_in,
    // Outputs
    output logic out1_out,
    output logic out2_out,
    output logic [preset_timer_pkg::VAL_W-1:0] value_out
);
    import preset_timer_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [MODE_W-1:0] mode;
    logic [VAL_W-1:0] preset1;
    logic [VAL_W-1:0] preset2;
    logic [VAL_W-1:0] otime1;
    logic [VAL_W-1:0] otime2;
    logic halted;
    logic run_prev;
    logic stopped_seen;
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire req = wb_cyc_in && wb_stb_in && !ack && !err;
    wire hit_mode = (wb_adr_in == OFS_MODE);
    wire hit_p1 = (wb_adr_in == OFS_PRESET1);
    wire hit_p2 = (wb_adr_in == OFS_PRESET2);
    wire hit_t1 = (wb_adr_in == OFS_OTIME1);
    wire hit_t2 = (wb_adr_in == OFS_OTIME2);
    wire hit_val = (wb_adr_in == OFS_VALUE);
    wire hit_st = (wb_adr_in == OFS_STATUS);
    wire hit_cmd = (wb_adr_in == OFS_CMD);
    wire mapped = hit_mode || hit_p1 || hit_p2 || hit_t1 || hit_t2 || hit_val
        || hit_st || hit_cmd;
    wire wr = req && wb_we_in && mapped;
    wire [MODE_W-1:0] mode_wdata = wb_dat_in[MODE_W-1:0];
    // Out-of-range mode writes are dropped so the decoder never sees 0 or 43+
    wire mode_ok = (mode_wdata >= MODE_MIN) && (mode_wdata <= MODE_MAX);
    wire cmd_reset = wr && hit_cmd && wb_sel_in[0] && wb_dat_in[CMD_RESET];

    // Merge byte lanes of a 24-bit register
    function automatic logic [VAL_W-1:0] merge24(input logic [VAL_W-1:0] old,
                                                 input logic [DATA_W-1:0] d,
                                                 input logic [3:0] sel);
        logic [VAL_W-1:0] r;
        r = old;
        for (int i = 0; i < 3; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            mode <= MODE_RST;
            preset1 <= PRESET1_RST;
            preset2 <= PRESET2_RST;
            otime1 <= OTIME_RST;
            otime2 <= OTIME_RST;
        end else if (wr) begin
            if (hit_mode && wb_sel_in[0] && mode_ok) begin
                mode <= mode_wdata;
            end
            if (hit_p1) begin
                preset1 <= merge24(preset1, wb_dat_in, wb_sel_in);
            end
            if (hit_p2) begin
                preset2 <= merge24(preset2, wb_dat_in, wb_sel_in);
            end
            if (hit_t1) begin
                otime1 <= merge24(otime1, wb_dat_in, wb_sel_in);
            end
            if (hit_t2) begin
                otime2 <= merge24(otime2, wb_dat_in, wb_sel_in);
            end
        end
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    logic stop_at_main;
    logic auto_reset;
    logic to_preset;
    logic at_end;
    out_kind_t kind1;
    out_kind_t kind2;

    timer_mode_decoder u_decode (
        .mode_in(mode),
        .stop_at_main_out(stop_at_main),
        .auto_reset_out(auto_reset),
        .reset_to_preset_out(to_preset),
        .at_timed_end_out(at_end),
        .out1_kind_out(kind1),
        .out2_kind_out(kind2)
    );

    // ------------------------------------------------------------
    // Counter core
    // ------------------------------------------------------------
    logic out2_end;
    wire manual_reset = user_reset_in || cmd_reset;
    wire counting = run_in && !halted;
    wire step = counting && count_tick_in;
    wire [VAL_W-1:0] reset_value = to_preset ? preset2 : VAL_ZERO;
    wire [VAL_W-1:0] step_value = to_preset ? value_out - VAL_ONE : value_out + VAL_ONE;
    // Main trigger on the step that reaches the target value
    wire main_hit = step && (to_preset ? (value_out == VAL_ONE)
        : (step_value == preset2));
    wire sec_hit = step && (step_value == preset1);
    wire auto_now = auto_reset && (at_end ? out2_end : main_hit);
    // Stop-then-run cycle: seen a stop, now run again
    wire run_restart = run_in && !run_prev && stopped_seen;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            value_out <= VAL_ZERO;
            halted <= 1'b0;
            run_prev <= 1'b0;
            stopped_seen <= 1'b0;
        end else begin
            run_prev <= run_in;
            if (!run_in) begin
                stopped_seen <= 1'b1;
            end else if (run_restart) begin
                stopped_seen <= 1'b0;
            end
            if (manual_reset || auto_now) begin
                value_out <= reset_value;
            end else if (step) begin
                value_out <= step_value;
            end
            // Halt wins over a run restart in the same cycle
            if (stop_at_main && main_hit) begin
                halted <= 1'b1;
            end else if (manual_reset || run_restart) begin
                halted <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs, one instance per output
    // ------------------------------------------------------------
    // Auto reset does not clear outputs so timed and latched ones keep running
    output_timer u_out2 (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .kind_in(kind2),
        .otime_in(otime2),
        .tick_in(count_tick_in),
        .trigger_in(main_hit),
        .clear_in(manual_reset),
        .off_event_in(1'b0),
        .active_out(out2_out),
        .timed_end_out(out2_end)
    );

    output_timer u_out1 (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .kind_in(kind1),
        .otime_in(otime1),
        .tick_in(count_tick_in),
        .trigger_in(sec_hit),
        .clear_in(manual_reset),
        .off_event_in(main_hit),
        .active_out(out1_out),
        .timed_end_out()
    );

    // ------------------------------------------------------------
    // Read path and acknowledge
    // ------------------------------------------------------------
    wire [DATA_W-1:0] status_word = {{(DATA_W-4){1'b0}}, counting, halted, out2_out, out1_out};
    wire [DATA_W-1:0] next_rdata =
        hit_mode ? {{(DATA_W-MODE_W){1'b0}}, mode} :
        hit_p1 ? {{(DATA_W-VAL_W){1'b0}}, preset1} :
        hit_p2 ? {{(DATA_W-VAL_W){1'b0}}, preset2} :
        hit_t1 ? {{(DATA_W-VAL_W){1'b0}}, otime1} :
        hit_t2 ? {{(DATA_W-VAL_W){1'b0}}, otime2} :
        hit_val ? {{(DATA_W-VAL_W){1'b0}}, value_out} :
        hit_st ? status_word : {DATA_W{1'b0}};

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ack <= 1'b0;
            err <= 1'b0;
            rdata <= {DATA_W{1'b0}};
        end else begin
            ack <= req && mapped;
            err <= req && !mapped;
            if (req) begin
                rdata <= next_rdata;
            end
        end
    end

    assign wb_ack_out = ack;
    assign wb_err_out = err;
    assign wb_dat_out = rdata;

endmodule

// ===== design/preset_timer_pkg.sv
/*
 * Shared constants and types for the dual-preset process timer.
 * Assumes a 32-bit classic Wishbone slave port and one 20 MHz clock.
 */
package preset_timer_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int VAL_W = 24;
    localparam int MODE_W = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_PRESET1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PRESET2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OTIME1 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_OTIME2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_VALUE = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CMD = 8'h1c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int ST_OUT1 = 0;
    localparam int ST_OUT2 = 1;
    localparam int ST_HALT = 2;
    localparam int ST_RUN = 3;
    localparam int CMD_RESET = 0;
    localparam logic [MODE_W-1:0] MODE_MIN = 6'h01;
    localparam logic [MODE_W-1:0] MODE_MAX = 6'h2a;
    localparam logic [MODE_W-1:0] MODE_RST = 6'h01;
    localparam logic [VAL_W-1:0] PRESET1_RST = 24'h000064;
    localparam logic [VAL_W-1:0] PRESET2_RST = 24'h0000c8;
    localparam logic [VAL_W-1:0] OTIME_RST = 24'h00000a;
    localparam logic [VAL_W-1:0] VAL_ZERO = 24'h000000;
    localparam logic [VAL_W-1:0] VAL_ONE = 24'h000001;

    // Output behaviour of one output
    typedef enum logic [1:0] {
        OUT_LATCHED = 2'b00,
        OUT_TIMED = 2'b01,
        OUT_OFF_AT_2 = 2'b10
    } out_kind_t;

endpackage

// ===== design/timer_mode_decoder.sv
/*
 * Decodes an operating mode number 1..42 into individual controls.
 * Assumes the mode value is already range checked by the register file.
 */
`timescale 1ns/100ps
module timer_mode_decoder (
    // Mode
    input wire logic [preset_timer_pkg::MODE_W-1:0] mode_in,
    // Decoded controls
    output logic stop_at_main_out,
    output logic auto_reset_out,
    output logic reset_to_preset_out,
    output logic at_timed_end_out,
    output preset_timer_pkg::out_kind_t out1_kind_out,
    output preset_timer_pkg::out_kind_t out2_kind_out
);
    import preset_timer_pkg::*;

    // ------------------------------------------------------------
    // Decode table
    // ------------------------------------------------------------
    // Modes 1..10 and 19..38 share a five-way output pattern.
    logic [MODE_W-1:0] grp_idx;
    logic [2:0] combo;
    logic parity_even;

    always_comb begin
        stop_at_main_out = (mode_in >= 6'h13);
        auto_reset_out = 1'b0;
        reset_to_preset_out = 1'b0;
        at_timed_end_out = 1'b0;
        grp_idx = 6'h00;
        parity_even = ~mode_in[0];
        if (mode_in <= 6'h0a) begin
            grp_idx = mode_in - 6'h01;
            reset_to_preset_out = (mode_in >= 6'h06);
        end else if (mode_in <= 6'h12) begin
            auto_reset_out = 1'b1;
            at_timed_end_out = (mode_in >= 6'h0f);
            reset_to_preset_out = (mode_in == 6'h0d) || (mode_in == 6'h0e)
                || (mode_in >= 6'h11);
            grp_idx = parity_even ? 6'h04 : 6'h02;
        end else if (mode_in <= 6'h1c) begin
            grp_idx = mode_in - 6'h13;
            reset_to_preset_out = (mode_in >= 6'h18);
        end else if (mode_in <= 6'h26) begin
            auto_reset_out = 1'b1;
            grp_idx = mode_in - 6'h1d;
            reset_to_preset_out = (mode_in >= 6'h22);
        end else begin
            auto_reset_out = 1'b1;
            at_timed_end_out = 1'b1;
            reset_to_preset_out = (mode_in >= 6'h29);
            grp_idx = parity_even ? 6'h04 : 6'h02;
        end
        combo = (grp_idx >= 6'h05) ? 3'(grp_idx - 6'h05) : grp_idx[2:0];
        unique case (combo)
            3'h0: begin
                out1_kind_out = OUT_LATCHED;
                out2_kind_out = OUT_LATCHED;
            end
            3'h1: begin
                out1_kind_out = OUT_TIMED;
                out2_kind_out = OUT_LATCHED;
            end
            3'h2: begin
                out1_kind_out = OUT_TIMED;
                out2_kind_out = OUT_TIMED;
            end
            3'h3: begin
                out1_kind_out = OUT_OFF_AT_2;
                out2_kind_out = OUT_LATCHED;
            end
            default: begin
                out1_kind_out = OUT_OFF_AT_2;
                out2_kind_out = OUT_TIMED;
            end
        endcase
    end

endmodule

// ===== design/output_timer.sv
/*
 * One timer output: latched, timed, or cleared when the main output fires.
 * Assumes trigger and clear are single-cycle pulses from the counter core.
 */
`timescale 1ns/100ps
module output_timer (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Control
    input wire preset_timer_pkg::out_kind_t kind_in,
    input wire logic [preset_timer_pkg::VAL_W-1:0] otime_in,
    input wire logic tick_in,
    input wire logic trigger_in,
    input wire logic clear_in,
    input wire logic off_event_in,
    // State
    output logic active_out,
    output logic timed_end_out
);
    import preset_timer_pkg::*;

    // ------------------------------------------------------------
    // Output state and interval counter
    // ------------------------------------------------------------
    logic [VAL_W-1:0] remain;
    wire timed = (kind_in == OUT_TIMED);
    wire expire = active_out && timed && tick_in && (remain <= VAL_ONE);
    wire drop = clear_in || expire || (off_event_in && kind_in == OUT_OFF_AT_2);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            active_out <= 1'b0;
            remain <= VAL_ZERO;
            timed_end_out <= 1'b0;
        end else begin
            timed_end_out <= expire;
            // A fresh trigger restarts a timed interval, even mid-interval
            if (trigger_in && !clear_in) begin
                active_out <= 1'b1;
                remain <= otime_in;
            end else if (drop) begin
                active_out <= 1'b0;
            end else if (active_out && timed && tick_in) begin
                remain <= remain - VAL_ONE;
            end
        end
    end

endmodule

// ===== verification/dual_preset_timer_chk.sv
/*
 * Port checker for the dual-preset timer core.
 * Assumes it is bound to the top module and sees its ports only.
 */
`timescale 1ns/100ps
module dual_preset_timer_chk (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Bus
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic [preset_timer_pkg::ADDR_W-1:0] wb_adr_in,
    input wire logic wb_ack_out,
    input wire logic wb_err_out,
    // Unit side
    input wire logic count_tick_in,
    input wire logic run_in,
    input wire logic user_reset_in,
    input wire logic out1_out,
    input wire logic out2_out,
    input wire logic [preset_timer_pkg::VAL_W-1:0] value_out
);
    import preset_timer_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    endsequence
    sequence s_answer;
        (wb_ack_out ^ wb_err_out) ##1 !(wb_ack_out || wb_err_out);
    endsequence
    property p_answer;
        s_req |=> s_answer;
    endproperty
    property p_ack_cause;
        (wb_ack_out || wb_err_out) |-> $past(wb_cyc_in && wb_stb_in);
    endproperty
    property p_map;
        wb_ack_out |-> ($past(wb_adr_in[7:5]) == 3'h0);
    endproperty
    // Reset itself is the condition here, so no disable
    property p_reset;
        disable iff (1'b0) reset_in |=> (value_out == VAL_ZERO) && !out1_out && !out2_out;
    endproperty
    property p_manual;
        user_reset_in |=> !out1_out && !out2_out;
    endproperty
    property p_rise2;
        $rose(out2_out) |-> $past(count_tick_in);
    endproperty
    property p_rise1;
        $rose(out1_out) |-> $past(count_tick_in);
    endproperty
    property p_hold;
        (!run_in && !count_tick_in && !user_reset_in && !wb_cyc_in)[*3] |=> $stable(value_out);
    endproperty

    a_answer: assert property (p_answer) else $error("bus answer missing or too long");
    a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
    a_map: assert property (p_map) else $error("ack on unmapped address");
    a_reset: assert property (p_reset) else $error("state not cleared by reset");
    a_manual: assert property (p_manual) else $error("outputs not cleared");
    a_rise2: assert property (p_rise2) else $error("main output rose without tick");
    a_rise1: assert property (p_rise1) else $error("first output rose without tick");
    a_hold: assert property (p_hold) else $error("value moved while stopped");
endmodule

// ===== verification/unit_model.sv
/*
 * Model of the surrounding unit: timebase ticks, run/stop and user reset.
 * Assumes one clock shared with the timer core.
 */
`timescale 1ns/100ps
module unit_model (
    // Clock
    input wire logic clk_in,
    // Unit lines
    output logic count_tick_out,
    output logic run_out,
    output logic user_reset_out
);
    initial begin
        count_tick_out = 1'b0;
        run_out = 1'b1;
        user_reset_out = 1'b0;
    end
    // Idle gap after each tick leaves room for end-of-interval reloads
    task automatic pulse_tick(input int n);
        repeat (n) begin
            @(posedge clk_in);
            count_tick_out <= 1'b1;
            @(posedge clk_in);
            count_tick_out <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
    endtask
    task automatic manual_reset();
        @(posedge clk_in);
        user_reset_out <= 1'b1;
        @(posedge clk_in);
        user_reset_out <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic run_cycle();
        @(posedge clk_in);
        run_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        run_out <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask
endmodule

// ===== verification/testbench.sv
/*
 * Self-checking bench for the dual-preset timer core.
 * Assumes the unit model drives ticks, run/stop and user reset.
 */
`timescale 1ns/100ps
module testbench;
    import preset_timer_pkg::*;
    typedef struct packed {
        logic [5:0] mode;
        logic [7:0] ticks;
        logic [23:0] rv;
        logic [23:0] v;
        logic o1;
        logic chk1;
        logic o2;
    } step_t;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [7:0] wb_adr_in = 8'h00;
    logic [3:0] wb_sel_in = 4'h0;
    logic [31:0] wb_dat_in = 32'h0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out, wb_err_out, count_tick_in, run_in, user_reset_in;
    logic out1_out, out2_out;
    logic [23:0] value_out;
    int failures = 0;
    int n_compared = 0;
    // Preset 1 = 3, preset 2 = 5, both output times = 2
    step_t steps [0:19] = '{
        '{6'h01, 8'd7, 24'd0, 24'd7, 1'b1, 1'b1, 1'b1},
        '{6'h03, 8'd9, 24'd0, 24'd9, 1'b0, 1'b1, 1'b0},
        '{6'h04, 8'd4, 24'd0, 24'd4, 1'b1, 1'b1, 1'b0},
        '{6'h04, 8'd6, 24'd0, 24'd6, 1'b0, 1'b1, 1'b1},
        '{6'h06, 8'd3, 24'd5, 24'd2, 1'b1, 1'b1, 1'b0},
        '{6'h0a, 8'd5, 24'd5, 24'd0, 1'b0, 1'b1, 1'b1},
        '{6'h0b, 8'd5, 24'd0, 24'd0, 1'b0, 1'b0, 1'b1},
        '{6'h0d, 8'd5, 24'd5, 24'd5, 1'b0, 1'b0, 1'b1},
        '{6'h0f, 8'd8, 24'd0, 24'd1, 1'b0, 1'b1, 1'b0},
        '{6'h13, 8'd8, 24'd0, 24'd5, 1'b1, 1'b1, 1'b1},
        '{6'h18, 8'd7, 24'd5, 24'd0, 1'b1, 1'b1, 1'b1},
        '{6'h1d, 8'd7, 24'd0, 24'd0, 1'b1, 1'b1, 1'b1},
        '{6'h22, 8'd7, 24'd5, 24'd5, 1'b1, 1'b1, 1'b1},
        '{6'h27, 8'd12, 24'd0, 24'd0, 1'b0, 1'b1, 1'b0},
        '{6'h02, 8'd7, 24'd0, 24'd7, 1'b0, 1'b1, 1'b1},
        '{6'h0e, 8'd6, 24'd5, 24'd4, 1'b0, 1'b1, 1'b1},
        '{6'h12, 8'd8, 24'd5, 24'd4, 1'b0, 1'b1, 1'b0},
        '{6'h1a, 8'd7, 24'd5, 24'd0, 1'b0, 1'b1, 1'b0},
        '{6'h1e, 8'd6, 24'd0, 24'd0, 1'b0, 1'b1, 1'b1},
        '{6'h2a, 8'd8, 24'd5, 24'd5, 1'b0, 1'b1, 1'b0}
    };

    always #25 clk_in = ~clk_in;

    dual_preset_timer i_dual_preset_timer (.clk_in(clk_in), .reset_in(reset_in),
        .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out),
        .count_tick_in(count_tick_in), .run_in(run_in), .user_reset_in(user_reset_in),
        .out1_out(out1_out), .out2_out(out2_out), .value_out(value_out));
    unit_model unit (.clk_in(clk_in), .count_tick_out(count_tick_in), .run_out(run_in),
        .user_reset_out(user_reset_in));

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb_access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
            input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= adr;
        wb_sel_in <= sel;
        wb_dat_in <= wd;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            print_verdict();
        end
        rd = wb_dat_out;
        err = wb_err_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [3:0] sel, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        wb_access(1'b1, adr, sel, d, rd, err);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] exp,
            input logic exp_err);
        logic [31:0] rd;
        logic err;
        wb_access(1'b0, adr, 4'hf, 32'h0, rd, err);
        compare(what, exp, rd);
        compare("bus error", {31'h0, exp_err}, {31'h0, err});
    endtask
    task automatic run_step(input step_t s);
        wr(OFS_MODE, 4'h1, {26'h0, s.mode});
        unit.manual_reset();
        compare("reset value", {8'h00, s.rv}, {8'h00, value_out});
        compare("reset outputs", 32'h0, {30'h0, out2_out, out1_out});
        unit.pulse_tick(int'(s.ticks));
        compare("value", {8'h00, s.v}, {8'h00, value_out});
        if (s.chk1) begin
            compare("out1", {31'h0, s.o1}, {31'h0, out1_out});
        end
        compare("out2", {31'h0, s.o2}, {31'h0, out2_out});
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        rd_chk("mode", OFS_MODE, 32'h1, 1'b0);
        rd_chk("preset1", OFS_PRESET1, 32'h64, 1'b0);
        rd_chk("preset2", OFS_PRESET2, 32'hc8, 1'b0);
        rd_chk("otime1", OFS_OTIME1, 32'ha, 1'b0);
        rd_chk("otime2", OFS_OTIME2, 32'ha, 1'b0);
        rd_chk("status", OFS_STATUS, 32'h8, 1'b0);
        rd_chk("unmapped", 8'h20, 32'h0, 1'b1);
        wr(OFS_VALUE, 4'hf, 32'h55);
        rd_chk("value reg", OFS_VALUE, 32'h0, 1'b0);
        // Lane 3 has no storage, lane 1 alone lands
        wr(OFS_PRESET1, 4'ha, 32'hffffabff);
        rd_chk("preset1 lane", OFS_PRESET1, 32'hab64, 1'b0);
        wr(OFS_MODE, 4'h1, 32'h0);
        wr(OFS_MODE, 4'h1, 32'h2b);
        wr(OFS_MODE, 4'he, 32'h5);
        rd_chk("mode refused", OFS_MODE, 32'h1, 1'b0);
        wr(OFS_MODE, 4'h1, 32'h2a);
        rd_chk("mode max", OFS_MODE, 32'h2a, 1'b0);
        wr(OFS_PRESET1, 4'hf, 32'h3);
        wr(OFS_PRESET2, 4'hf, 32'h5);
        wr(OFS_OTIME1, 4'hf, 32'h2);
        wr(OFS_OTIME2, 4'hf, 32'h2);
        foreach (steps[i]) begin
            run_step(steps[i]);
        end
        run_step(steps[9]);
        rd_chk("halted status", OFS_STATUS, 32'h7, 1'b0);
        unit.run_cycle();
        rd_chk("restart status", OFS_STATUS, 32'hb, 1'b0);
        unit.pulse_tick(2);
        compare("value after restart", 32'h7, {8'h00, value_out});
        wr(OFS_CMD, 4'hf, 32'h1);
        rd_chk("cmd reset value", OFS_VALUE, 32'h0, 1'b0);
        rd_chk("cmd reset status", OFS_STATUS, 32'h8, 1'b0);
        print_verdict();
    end
endmodule

bind dual_preset_timer dual_preset_timer_chk chk (.clk_in(clk_in), .reset_in(reset_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_adr_in(wb_adr_in),
    .wb_ack_out(wb_ack_out), .wb_err_out(wb_err_out), .count_tick_in(count_tick_in),
    .run_in(run_in), .user_reset_in(user_reset_in), .out1_out(out1_out),
    .out2_out(out2_out), .value_out(value_out));
